// file: rtl/msc_pkg.sv
// constants shared by the module standby clock gate block
//
// Notes on behaviour
// - standby stops the peripheral clock, halting it
// - each peripheral has its own stop bit
// - writing zero to a stop bit: standby
// - writing one restores the peripheral clock
// - both stop registers reset to all ones
// - register one: timer a, timer f, converter, serial
// - register two: lcd, pwm one, counter, pwm two
// - active to subactive passes through watch state
// - sub to medium: sleep states, watch, wait, exception
// - rom reads, byte or word, in two states
// - rom capacity 16, 12 or 8 kbytes
// - prom mode halts cpu, byte programming only
package msc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_STOP_ONE  = 8'h00;
	localparam logic [7:0] ADDR_STOP_TWO  = 8'h01;
	localparam logic [7:0] ADDR_PWR_CTRL  = 8'h02;
	localparam logic [7:0] ADDR_PWR_STAT  = 8'h03;
	localparam logic [7:0] STOP_RESET     = 8'hff;
	localparam logic [7:0] READ_UNMAPPED  = 8'h00;

	// stop register one bits
	localparam int TIMER_A_GATE     = 0;
	localparam int TIMER_F_GATE     = 1;
	localparam int CONVERTER_GATE   = 2;
	localparam int SERIAL_THREE_GATE = 3;
	// stop register two bits
	localparam int LCD_GATE         = 0;
	localparam int PWM_ONE_GATE     = 1;
	localparam int EVENT_COUNTER_GATE = 2;
	localparam int PWM_TWO_GATE     = 3;
	localparam int NUM_PERIPH       = 8;

	// power control fields
	localparam int PC_TARGET_LO     = 0;
	localparam int PC_TARGET_HI     = 1;
	localparam int PC_WAIT_LO       = 2;
	localparam int PC_WAIT_HI       = 4;
	localparam int PC_GO            = 7;

	// ----------------------------------------------------------------
	// power modes and transition timing
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {MODE_HIGH, MODE_MED, MODE_SUB, MODE_RSVD} msc_mode_t;
	typedef enum {ST_RUN, ST_SLEEP, ST_WATCH, ST_WAIT, ST_EXCEPT} msc_state_t;

	localparam logic [14:0] SLEEP_STATES  = 15'h0003; // sleep execution 2 + internal 1
	localparam logic [14:0] EXCEPT_STATES = 15'h000e; // 14 exception handling states
	localparam logic [14:0] WATCH_STATES  = 15'h0001;
	localparam int          MED_DIV       = 8;        // medium speed tick every 8 clocks
	localparam int          SUB_DIV       = 64;       // subclock tick every 64 clocks

	// wait states selected by wake_wait_select
	localparam logic [14:0] WAIT_TABLE [8] = '{15'h2000, 15'h4000, 15'h0400, 15'h0800,
		15'h1000, 15'h0002, 15'h0008, 15'h0010};

	// ----------------------------------------------------------------
	// on-chip rom
	// ----------------------------------------------------------------
	localparam int ROM_AW       = 14;     // byte address width
	localparam int ROM_WORDS    = 8192;   // 16 kbytes as 16-bit words
	localparam int ROM_16K      = 16384;
	localparam int ROM_12K      = 12288;
	localparam int ROM_8K       = 8192;
	localparam int PIN_SYNC_W   = 27;     // mode, pgm, oe, addr 14, data 8, ce, spare

endpackage : msc_pkg

// file: rtl/msc_gate_cell.sv
// one glitch-free clock gate for a single peripheral
`timescale 1ns/1ns
module msc_gate_cell
	import msc_pkg::*;
(
	input  wire logic clk,       // system clock
	input  wire logic rst_n,     // synchronous reset, active low
	input  wire logic run,       // clock enable from the stop register
	output logic      clk_out    // gated peripheral clock
);

	logic en_low_reg;

	// enable on low phase
	// the enable only moves at the falling edge, so clk_out never gets a short pulse
	always_ff @(negedge clk) begin
		if (!rst_n) begin
			en_low_reg <= 1'b1;
		end else begin
			en_low_reg <= run;
		end
	end

	assign clk_out = clk & en_low_reg;

endmodule : msc_gate_cell

// file: rtl/msc_rom_mem.sv
// on-chip program memory, 16-bit words, registered read data
`timescale 1ns/1ns
module msc_rom_mem
	import msc_pkg::*;
(
	input  wire logic              clk,      // system clock
	input  wire logic              rd_en,    // read strobe
	input  wire logic [ROM_AW-2:0] rd_word,  // word address for read
	output logic      [15:0]       rd_data,  // registered read word
	input  wire logic              wr_en,    // byte write strobe
	input  wire logic [ROM_AW-1:0] wr_addr,  // byte address for write
	input  wire logic [7:0]        wr_byte   // byte to program
);

	logic [15:0] mem [ROM_WORDS];

	// read port, data from a register
	always_ff @(posedge clk) begin
		if (rd_en) begin
			rd_data <= mem[rd_word];
		end
	end

	always_ff @(posedge clk) begin
		if (wr_en && wr_addr[0]) begin
			mem[wr_addr[ROM_AW-1:1]][7:0] <= wr_byte;
		end else if (wr_en) begin
			mem[wr_addr[ROM_AW-1:1]][15:8] <= wr_byte;
		end
	end

endmodule : msc_rom_mem

// file: rtl/msc_standby_top.sv
// module standby clock gating, power mode sequencer and on-chip rom access
`timescale 1ns/1ns
module msc_standby_top
	import msc_pkg::*;
#(
	parameter int ROM_BYTES = ROM_16K   // device variant capacity
)(
	input  wire logic              clk,            // system clock, 50 MHz
	input  wire logic              rst_n,          // synchronous reset, active low
	input  wire logic [7:0]        reg_addr,       // register address
	input  wire logic [7:0]        reg_wdata,      // register write data
	input  wire logic              reg_wr,         // write strobe
	input  wire logic              reg_rd,         // read strobe
	output logic      [7:0]        reg_rdata,      // read data, cycle after strobe
	output logic      [7:0]        periph_clk,     // gated peripheral clocks
	output logic      [7:0]        periph_run,     // peripheral clock running flags
	input  wire logic              cpu_rom_req,    // cpu rom read request
	input  wire logic [ROM_AW-1:0] cpu_rom_addr,   // cpu rom byte address
	input  wire logic              cpu_rom_word,   // 1 word read, 0 byte read
	output logic      [15:0]       cpu_rom_rdata,  // rom read data
	output logic                   cpu_rom_ack,    // rom read done pulse
	output logic                   cpu_halt,       // cpu stopped for prom mode
	output logic      [1:0]        power_mode,     // current power mode
	output logic                   power_busy,     // transition in progress
	input  wire logic              prom_mode_pin,  // prom mode strap pin
	input  wire logic              prom_ce_n_pin,  // chip enable pin
	input  wire logic              prom_oe_n_pin,  // output enable pin
	input  wire logic              prom_pgm_n_pin, // program pulse pin
	input  wire logic [ROM_AW-1:0] prom_addr_pin,  // programming address pins
	input  wire logic [7:0]        prom_data_in,   // data pins, input side
	output logic      [7:0]        prom_data_out,  // data pins, output side
	output logic                   prom_data_oe_n  // data pins enable, low drives
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [PIN_SYNC_W-1:0] pin_meta_reg;
	logic [PIN_SYNC_W-1:0] pin_sync_reg;
	logic [PIN_SYNC_W-1:0] pin_raw;

	assign pin_raw = {1'b0, prom_ce_n_pin, prom_mode_pin, prom_pgm_n_pin, prom_oe_n_pin,
		prom_addr_pin, prom_data_in};

	// two flops on every pin before use
	always_ff @(posedge clk) begin
		pin_meta_reg <= pin_raw;
		pin_sync_reg <= pin_meta_reg;
	end

	wire              s_ce_n  = pin_sync_reg[25];
	wire              s_mode  = pin_sync_reg[24];
	wire              s_pgm_n = pin_sync_reg[23];
	wire              s_oe_n  = pin_sync_reg[22];
	wire [ROM_AW-1:0] s_addr  = pin_sync_reg[21:8];
	wire [7:0]        s_data  = pin_sync_reg[7:0];

	// ----------------------------------------------------------------
	// prom mode
	// ----------------------------------------------------------------
	logic prom_mode_reg;
	logic pgm_n_prev_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prom_mode_reg  <= 1'b0;
			pgm_n_prev_reg <= 1'b1;
		end else begin
			prom_mode_reg  <= s_mode;
			pgm_n_prev_reg <= s_pgm_n;
		end
	end

	// byte write only
	// one byte per program pulse; no page buffer exists, so page mode cannot work
	wire prom_write  = prom_mode_reg && !s_ce_n && s_oe_n && !s_pgm_n && pgm_n_prev_reg;
	wire prom_verify = prom_mode_reg && !s_ce_n && !s_oe_n && s_pgm_n;
	wire prom_in_rng = ({1'b0, s_addr} < 15'(ROM_BYTES));

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [7:0] stop_one_reg;
	logic [7:0] stop_two_reg;
	logic [2:0] wait_sel_reg;
	logic [1:0] target_reg;
	logic       go_reg;
	logic [7:0] rdata_reg;

	wire hit_one  = reg_addr == ADDR_STOP_ONE;
	wire hit_two  = reg_addr == ADDR_STOP_TWO;
	wire hit_ctrl = reg_addr == ADDR_PWR_CTRL;
	wire hit_stat = reg_addr == ADDR_PWR_STAT;
	wire req_go   = reg_wr && hit_ctrl && reg_wdata[PC_GO];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stop_one_reg <= STOP_RESET;
			stop_two_reg <= STOP_RESET;
		end else if (reg_wr && hit_one) begin
			stop_one_reg <= reg_wdata;
		end else if (reg_wr && hit_two) begin
			stop_two_reg <= reg_wdata;
		end
	end

	// power control fields
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wait_sel_reg <= 3'h0;
			target_reg   <= MODE_HIGH;
		end else if (reg_wr && hit_ctrl) begin
			wait_sel_reg <= reg_wdata[PC_WAIT_HI:PC_WAIT_LO];
			target_reg   <= reg_wdata[PC_TARGET_HI:PC_TARGET_LO];
		end
	end

	// read data mux
	logic       seq_busy;
	logic [1:0] mode_reg;
	wire  [7:0] status_word = {3'h0, prom_mode_reg, 1'b0, seq_busy, mode_reg};
	wire  [7:0] ctrl_word   = {3'h0, wait_sel_reg, target_reg};
	wire  [7:0] rd_mux      = hit_one  ? stop_one_reg :
	                          hit_two  ? stop_two_reg :
	                          hit_ctrl ? ctrl_word :
	                          hit_stat ? status_word : READ_UNMAPPED;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			rdata_reg <= rd_mux;
		end
	end

	assign reg_rdata = rdata_reg;

	// ----------------------------------------------------------------
	// peripheral clock gates
	// ----------------------------------------------------------------
	logic [7:0] run_reg;

	// prom mode stops every peripheral as well
	wire [7:0] run_next = prom_mode_reg ? 8'h00 :
		{stop_two_reg[PWM_TWO_GATE], stop_two_reg[EVENT_COUNTER_GATE],
		 stop_two_reg[PWM_ONE_GATE], stop_two_reg[LCD_GATE],
		 stop_one_reg[SERIAL_THREE_GATE], stop_one_reg[CONVERTER_GATE],
		 stop_one_reg[TIMER_F_GATE], stop_one_reg[TIMER_A_GATE]};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_reg <= STOP_RESET;
		end else begin
			run_reg <= run_next;
		end
	end

	assign periph_run = run_reg;

	genvar g;
	generate
		for (g = 0; g < NUM_PERIPH; g++) begin : gen_gate
			msc_gate_cell u_gate (
				.clk     (clk),
				.rst_n   (rst_n),
				.run     (run_reg[g]),
				.clk_out (periph_clk[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// state rate dividers
	// ----------------------------------------------------------------
	logic [5:0] sub_div_reg;
	logic [2:0] med_div_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sub_div_reg <= 6'h00;
			med_div_reg <= 3'h0;
		end else begin
			sub_div_reg <= sub_div_reg + 6'h01;
			med_div_reg <= med_div_reg + 3'h1;
		end
	end

	wire sub_tick = sub_div_reg == 6'(SUB_DIV - 1);
	wire med_tick = med_div_reg == 3'(MED_DIV - 1);

	function automatic logic tick_of(input logic [1:0] m, input logic st, input logic mt);
		case (m)
			MODE_HIGH: tick_of = 1'b1;
			MODE_MED:  tick_of = mt;
			MODE_SUB:  tick_of = st;
			default:   tick_of = 1'b1;
		endcase
	endfunction : tick_of

	// ----------------------------------------------------------------
	// power mode transition sequencer
	// ----------------------------------------------------------------
	msc_state_t  state_reg;
	msc_state_t  state_next;
	logic [1:0]  dest_reg;
	logic [14:0] cnt_reg;
	logic [14:0] wait_reg;

	wire old_tick = tick_of(mode_reg, sub_tick, med_tick);
	wire new_tick = tick_of(dest_reg, sub_tick, med_tick);
	wire cnt_done = cnt_reg == 15'h0001;
	wire to_sub   = dest_reg == MODE_SUB;
	wire from_sub = mode_reg == MODE_SUB;
	wire cmd_ok   = req_go && !prom_mode_reg && reg_wdata[PC_TARGET_HI:PC_TARGET_LO] != mode_reg
		&& reg_wdata[PC_TARGET_HI:PC_TARGET_LO] != MODE_RSVD;
	wire tick_now = (state_reg == ST_SLEEP) ? old_tick : new_tick;

	// next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (cmd_ok) begin
					state_next = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (old_tick && cnt_done) begin
					state_next = (to_sub || from_sub) ? ST_WATCH : ST_EXCEPT;
				end
			end
			ST_WATCH: begin
				if (old_tick && cnt_done) begin
					state_next = to_sub ? ST_RUN : ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (new_tick && cnt_done) begin
					state_next = ST_EXCEPT;
				end
			end
			ST_EXCEPT: begin
				if (new_tick && cnt_done) begin
					state_next = ST_RUN;
				end
			end
			default: state_next = ST_RUN;
		endcase
	end

	// state, destination and mode registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= ST_RUN;
			dest_reg  <= MODE_HIGH;
			mode_reg  <= MODE_HIGH;
			wait_reg  <= 15'h0000;
		end else begin
			state_reg <= state_next;
			if (state_reg == ST_RUN && cmd_ok) begin
				dest_reg <= reg_wdata[PC_TARGET_HI:PC_TARGET_LO];
				wait_reg <= WAIT_TABLE[reg_wdata[PC_WAIT_HI:PC_WAIT_LO]];
			end
			if (state_reg != ST_RUN && state_next == ST_RUN) begin
				mode_reg <= dest_reg;
			end
		end
	end

	// state counter
	// each phase loads its length; counting follows the rate of that phase
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg <= 15'h0000;
		end else if (state_next != state_reg) begin
			case (state_next)
				ST_SLEEP:  cnt_reg <= SLEEP_STATES;
				ST_WATCH:  cnt_reg <= WATCH_STATES;
				ST_WAIT:   cnt_reg <= wait_reg;
				ST_EXCEPT: cnt_reg <= EXCEPT_STATES;
				default:   cnt_reg <= 15'h0000;
			endcase
		end else if (tick_now && !cnt_done && state_reg != ST_RUN) begin
			cnt_reg <= cnt_reg - 15'h0001;
		end
	end

	assign seq_busy = state_reg != ST_RUN;

	logic       busy_reg;
	logic [1:0] mode_out_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_reg     <= 1'b0;
			mode_out_reg <= MODE_HIGH;
		end else begin
			busy_reg     <= state_next != ST_RUN;
			mode_out_reg <= (state_reg != ST_RUN && state_next == ST_RUN) ? dest_reg : mode_reg;
		end
	end

	assign power_busy = busy_reg;
	assign power_mode = mode_out_reg;

	// ----------------------------------------------------------------
	// rom access
	// ----------------------------------------------------------------
	logic [15:0] mem_data;
	logic        rd_pend_reg;
	logic        byte_reg;
	logic        odd_reg;
	logic        range_reg;
	logic        ack_reg;
	logic [15:0] rom_data_reg;
	logic        halt_reg;

	wire cpu_in_rng = ({1'b0, cpu_rom_addr} < 15'(ROM_BYTES));
	wire cpu_take   = cpu_rom_req && !prom_mode_reg;
	wire mem_rd     = cpu_take || prom_verify;
	wire [ROM_AW-2:0] mem_word = prom_mode_reg ? s_addr[ROM_AW-1:1] : cpu_rom_addr[ROM_AW-1:1];

	msc_rom_mem u_rom (
		.clk     (clk),
		.rd_en   (mem_rd),
		.rd_word (mem_word),
		.rd_data (mem_data),
		.wr_en   (prom_write && prom_in_rng),
		.wr_addr (s_addr),
		.wr_byte (s_data)
	);

	// two-state read
	// state one reads the array, state two steers the byte lane and answers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_pend_reg  <= 1'b0;
			byte_reg     <= 1'b0;
			odd_reg      <= 1'b0;
			range_reg    <= 1'b0;
			ack_reg      <= 1'b0;
			rom_data_reg <= 16'h0000;
		end else begin
			rd_pend_reg <= cpu_take;
			byte_reg    <= !cpu_rom_word;
			odd_reg     <= prom_mode_reg ? s_addr[0] : cpu_rom_addr[0];
			range_reg   <= prom_mode_reg ? prom_in_rng : cpu_in_rng;
			ack_reg     <= rd_pend_reg;
			if (rd_pend_reg && !range_reg) begin
				rom_data_reg <= 16'h0000;
			end else if (rd_pend_reg && byte_reg) begin
				rom_data_reg <= {8'h00, odd_reg ? mem_data[7:0] : mem_data[15:8]};
			end else if (rd_pend_reg) begin
				rom_data_reg <= mem_data;
			end
		end
	end

	assign cpu_rom_rdata = rom_data_reg;
	assign cpu_rom_ack   = ack_reg;

	logic [7:0] pdout_reg;
	logic       poe_n_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pdout_reg <= 8'h00;
			poe_n_reg <= 1'b1;
			halt_reg  <= 1'b0;
		end else begin
			halt_reg  <= prom_mode_reg;
			poe_n_reg <= !prom_verify;
			if (prom_verify) begin
				pdout_reg <= !range_reg ? 8'h00 : (odd_reg ? mem_data[7:0] : mem_data[15:8]);
			end
		end
	end

	assign prom_data_out  = pdout_reg;
	assign prom_data_oe_n = poe_n_reg;
	assign cpu_halt       = halt_reg;

endmodule : msc_standby_top

// file: verif/msc_periph_model.sv
// peripheral stand-ins that count the edges of their gated clocks
`timescale 1ns/1ns
module msc_periph_model
	import msc_pkg::*;
(
	input  wire logic       rst_n,                // reset, active low
	input  wire logic [7:0] periph_clk,           // gated peripheral clocks
	output logic      [7:0] ticks [NUM_PERIPH]    // edges seen by each peripheral
);
	// each peripheral halts with its own clock
	for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_pe
		always_ff @(posedge periph_clk[i]) begin
			if (!rst_n)
				ticks[i] <= 8'h00;
			else
				ticks[i] <= ticks[i] + 8'h01;
		end
	end
endmodule : msc_periph_model

// file: verif/msc_standby_chk.sv
// assertions on the ports of the standby clock gate top
`timescale 1ns/1ns
module msc_standby_chk
	import msc_pkg::*;
#(
	parameter int ROM_BYTES = ROM_16K  // rom capacity of the variant
)(
	input wire logic       clk,          // system clock
	input wire logic       rst_n,        // reset, active low
	input wire logic [7:0] reg_addr,     // register address
	input wire logic [7:0] reg_wdata,    // register write data
	input wire logic       reg_wr,       // write strobe
	input wire logic       reg_rd,       // read strobe
	input wire logic [7:0] reg_rdata,    // read data
	input wire logic [7:0] periph_clk,   // gated clocks
	input wire logic [7:0] periph_run,   // run flags
	input wire logic       cpu_rom_req,  // rom request
	input wire logic       cpu_rom_ack,  // rom answer
	input wire logic       cpu_halt,     // prom mode halt
	input wire logic [1:0] power_mode,   // power mode
	input wire logic       power_busy    // transition busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------------------------------
	// gating, register, rom and power mode relations
	// ----------------------------------------------------------------
	a_reset_all_run: assert property ($rose(rst_n) |-> periph_run == 8'hff && power_mode == 2'h0)
		else $error("run flags or mode wrong after reset");
	a_stop_one_run: assert property (reg_wr && reg_addr == ADDR_STOP_ONE && !cpu_halt ##2 !cpu_halt
		|-> periph_run[3:0] == $past(reg_wdata[3:0], 2)) else $error("stop one not applied");
	a_stop_two_run: assert property (reg_wr && reg_addr == ADDR_STOP_TWO && !cpu_halt ##2 !cpu_halt
		|-> periph_run[7:4] == $past(reg_wdata[3:0], 2)) else $error("stop two not applied");
	a_gate_low_phase: assert property (periph_clk == 8'h00)
		else $error("gated clock high while clock low");
	a_gate_follows_run: assert property (@(negedge clk) periph_clk == $past(periph_run))
		else $error("gated clock does not follow run flag");
	a_unmapped_zero: assert property (reg_rd && reg_addr > ADDR_PWR_STAT |=> reg_rdata == READ_UNMAPPED)
		else $error("unmapped read not zero");
	a_rom_two_states: assert property (cpu_rom_req && !cpu_halt |-> ##2 cpu_rom_ack)
		else $error("rom answer late");
	a_ack_has_req: assert property (cpu_rom_ack |-> $past(cpu_rom_req, 2))
		else $error("rom answer without request");
	a_prom_no_ack: assert property (cpu_rom_req && cpu_halt |-> ##2 !cpu_rom_ack)
		else $error("rom answered in prom mode");
	a_prom_clocks_off: assert property (cpu_halt [*3] |-> periph_run == 8'h00)
		else $error("peripheral clocks run in prom mode");
	a_mode_after_busy: assert property ($changed(power_mode) |-> $past(power_busy))
		else $error("mode changed without transition");
	c_gate_stopped: cover property (!periph_run[7] ##1 !periph_run[7]);
	c_med_reached: cover property ($fell(power_busy) && power_mode == 2'h1);
	c_rom_answer: cover property (cpu_rom_ack ##1 cpu_rom_ack);
endmodule : msc_standby_chk

// file: verif/msc_standby_top_tb.sv
// self-checking bench for the standby clock gate top
`timescale 1ns/1ns
module msc_standby_top_tb;
	import msc_pkg::*;
	localparam int ROM_SIZE = ROM_8K;  // smallest variant, so its end is reachable
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic [7:0]        reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic              reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0]        periph_clk, periph_run, prom_data_out;
	logic              cpu_rom_req = 1'b0, cpu_rom_word = 1'b0, cpu_rom_ack, cpu_halt;
	logic [ROM_AW-1:0] cpu_rom_addr = '0, prom_addr_pin = '0;
	logic [15:0]       cpu_rom_rdata;
	logic [1:0]        power_mode;
	logic              power_busy, prom_data_oe_n, prom_mode_pin = 1'b0;
	logic              prom_ce_n_pin = 1'b1, prom_oe_n_pin = 1'b1, prom_pgm_n_pin = 1'b1;
	logic [7:0]        prom_data_in = 8'h00;
	logic [7:0]        ticks [NUM_PERIPH];
	int                bad_count = 0, checked = 0, cycles = 0;

	msc_standby_top #(.ROM_BYTES(ROM_SIZE)) uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.periph_clk(periph_clk), .periph_run(periph_run), .cpu_rom_req(cpu_rom_req),
		.cpu_rom_addr(cpu_rom_addr), .cpu_rom_word(cpu_rom_word), .cpu_rom_rdata(cpu_rom_rdata),
		.cpu_rom_ack(cpu_rom_ack), .cpu_halt(cpu_halt), .power_mode(power_mode),
		.power_busy(power_busy), .prom_mode_pin(prom_mode_pin), .prom_ce_n_pin(prom_ce_n_pin),
		.prom_oe_n_pin(prom_oe_n_pin), .prom_pgm_n_pin(prom_pgm_n_pin),
		.prom_addr_pin(prom_addr_pin), .prom_data_in(prom_data_in),
		.prom_data_out(prom_data_out), .prom_data_oe_n(prom_data_oe_n));
	msc_periph_model u_pe (.rst_n(rst_n), .periph_clk(periph_clk), .ticks(ticks));

	// clock and hang guard
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			bad_count++;
			results();
		end
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h got %h", name, exp, got);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
	endtask : do_reset
	// programmer sends one byte per pulse
	task automatic prom_pulse(input logic [13:0] a, input logic [7:0] v);
		@(posedge clk);
		prom_addr_pin <= a;
		prom_data_in <= v;
		repeat (4) @(posedge clk);
		prom_pgm_n_pin <= 1'b0;
		repeat (6) @(posedge clk);
		prom_pgm_n_pin <= 1'b1;
		repeat (6) @(posedge clk);
	endtask : prom_pulse
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_vals(input string nm);
		logic [7:0] d;
		rd(ADDR_STOP_ONE, d);
		chk("stop_one", STOP_RESET, d);
		rd(ADDR_STOP_TWO, d);
		chk("stop_two", STOP_RESET, d);
		chk("run_flags", 8'hff, periph_run);
		chk("mode", 2'h0, power_mode);
		rd(8'h07, d);
		chk("unmapped", READ_UNMAPPED, d);
		$display("test %s done", nm);
	endtask : t_reset_vals
	task automatic t_gates();
		logic [7:0] snap [NUM_PERIPH];
		int         bit_of [NUM_PERIPH];
		bit_of = '{TIMER_A_GATE, TIMER_F_GATE, CONVERTER_GATE, SERIAL_THREE_GATE,
			LCD_GATE, PWM_ONE_GATE, EVENT_COUNTER_GATE, PWM_TWO_GATE};
		for (int p = 0; p < NUM_PERIPH; p++) begin
			wr(p < 4 ? ADDR_STOP_ONE : ADDR_STOP_TWO, 8'hff ^ (8'h01 << bit_of[p]));
			repeat (4) @(posedge clk);
			#1 snap = ticks;
			repeat (10) @(posedge clk);
			#1;
			for (int j = 0; j < NUM_PERIPH; j++)
				chk("ticks", (j == p) ? snap[j] : 8'(snap[j] + 8'h0a), ticks[j]);
			chk("run", 8'hff ^ (8'h01 << p), periph_run);
			wr(p < 4 ? ADDR_STOP_ONE : ADDR_STOP_TWO, 8'hff);
			repeat (3) @(posedge clk);
			#1 chk("resume", 8'hff, periph_run);
		end
		$display("test gates done");
	endtask : t_gates
	task automatic t_power();
		logic [7:0] d;
		logic [7:0] cmd [3];
		int         tmin [3];
		int         n;
		cmd = '{8'h81, 8'h82, 8'h95};
		// dividers run free, so the first state of each phase may be up to one period short
		tmin = '{108, 24, 320};
		for (int k = 0; k < 3; k++) begin
			wr(ADDR_PWR_CTRL, cmd[k]);
			n = 0;
			while ((n < 4 || power_busy !== 1'b0) && n < 3000) begin
				@(posedge clk);
				#1 n++;
			end
			chk("mode", cmd[k][1:0], power_mode);
			chk("time", 1'b1, n >= tmin[k] && n <= tmin[k] + 80);
			rd(ADDR_PWR_STAT, d);
			chk("status", {1'b0, cmd[k][1:0]}, d[2:0]);
		end
		$display("test power done");
	endtask : t_power
	task automatic t_prom_rom();
		@(posedge clk);
		prom_mode_pin <= 1'b1;
		prom_ce_n_pin <= 1'b0;
		repeat (8) @(posedge clk);
		cpu_rom_req <= 1'b1;
		@(posedge clk);
		cpu_rom_req <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("halt", 1'b1, cpu_halt);
		chk("refused", 1'b0, cpu_rom_ack);
		chk("prom_clocks", 8'h00, periph_run);
		prom_pulse(14'h0010, 8'ha5);
		prom_pulse(14'h0011, 8'h3c);
		prom_oe_n_pin <= 1'b0;
		prom_addr_pin <= 14'h0010;
		prom_data_in <= 8'h5a;
		repeat (8) @(posedge clk);
		#1 chk("verify_oe", 1'b0, prom_data_oe_n);
		chk("verify_data", 8'ha5, prom_data_out);
		prom_oe_n_pin <= 1'b1;
		prom_ce_n_pin <= 1'b1;
		prom_mode_pin <= 1'b0;
		repeat (8) @(posedge clk);
		#1 chk("released", 1'b1, prom_data_oe_n);
		chk("running", 1'b0, cpu_halt);
		@(posedge clk);
		cpu_rom_req <= 1'b1;
		cpu_rom_addr <= 14'h0010;
		cpu_rom_word <= 1'b1;
		@(posedge clk);
		cpu_rom_addr <= 14'h0011;
		cpu_rom_word <= 1'b0;
		// first answer stands in the cycle after the edge that follows the array read edge
		@(posedge clk);
		cpu_rom_addr <= ROM_SIZE[ROM_AW-1:0];
		cpu_rom_word <= 1'b1;
		#1 chk("word", 16'ha53c, cpu_rom_rdata);
		chk("ack", 1'b1, cpu_rom_ack);
		@(posedge clk);
		cpu_rom_req <= 1'b0;
		#1 chk("byte", 8'h3c, cpu_rom_rdata[7:0]);
		chk("ack_byte", 1'b1, cpu_rom_ack);
		@(posedge clk);
		#1 chk("beyond", 16'h0000, cpu_rom_rdata);
		$display("test prom_rom done");
	endtask : t_prom_rom

	// main sequence
	initial begin
		do_reset();
		t_reset_vals("reset");
		t_gates();
		t_power();
		t_prom_rom();
		wr(ADDR_STOP_ONE, 8'h00);
		do_reset();
		t_reset_vals("second_reset");
		results();
	end
endmodule : msc_standby_top_tb

bind msc_standby_top msc_standby_chk #(.ROM_BYTES(ROM_BYTES)) u_chk (.clk(clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .periph_clk(periph_clk), .periph_run(periph_run),
	.cpu_rom_req(cpu_rom_req), .cpu_rom_ack(cpu_rom_ack), .cpu_halt(cpu_halt),
	.power_mode(power_mode), .power_busy(power_busy));
